// file: flmc_cfg.svh
`ifndef FLMC_CFG_SVH
`define FLMC_CFG_SVH
// status register bit positions
`define FLMC_BIT_SHORT 0
`define FLMC_BIT_OVERHEAT 2
`define FLMC_BIT_EXCESS 3
`define FLMC_BIT_WARN 4
`define FLMC_BIT_OPEN 5
`define FLMC_BIT_RUN 6
`define FLMC_STAT_RESET 8'h00
// timing in ns and derived cycle counts at 4 ns
`define FLMC_CLK_NS 4
`define FLMC_POR_NS 1000
`define FLMC_POR_CYC ((`FLMC_POR_NS + `FLMC_CLK_NS - 1) / `FLMC_CLK_NS)
`define FLMC_CHARGE_NS 360000
`define FLMC_CHARGE_CYC (`FLMC_CHARGE_NS / `FLMC_CLK_NS)
`define FLMC_ATNPULSE_NS 11000
`define FLMC_ATNPULSE_CYC ((`FLMC_ATNPULSE_NS + `FLMC_CLK_NS - 1) / `FLMC_CLK_NS)
`endif

// file: flmc_pkg.sv
package flmc_pkg;
    typedef enum logic [2:0] {
        FLMC_POR = 3'b000,
        FLMC_CHECK = 3'b100,
        FLMC_SHUT = 3'b101,
        FLMC_READY = 3'b111,
        FLMC_FLASH = 3'b110,
        FLMC_TORCH = 3'b011
    } flmc_mode_type;
endpackage

// file: flmc_mode_ctrl.sv
`include "flmc_cfg.svh"
// Function
// - at start-up set short flag, charge output ~360 us, clear flag on 100 mV
// - threshold never reached: flag stays high, attention low, converter stays off
// - short flag clears when host reads the status register
// - four fault flags latch, pull attention low, clear only on status read
// - flash-running flag follows flash state live, never drives attention
// - open, excess, overheat, short flags force ready; warning does not
// - power-on: ~1 us reset, ignore inputs, defaults, float pins, sample address
// - shutdown keeps only serial alive; entered from reset or power bit clear
// - power bit and thermistor enable both set close thermistor switch
// - ready: converter off, LED disconnected, aux LED allowed only here
// - ready from standby, flash end by pin, arm clear or zero, torch clear
// - pin timing: flash lasts the pin pulse; repeated strobes give repeated flashes
// - time-out counter accumulates flash time; command write reloads it
// - time-out clears arm and running flag, goes ready, pulls attention low
// - arm-bit control: host holds pin high; time-out still enforced
// - soft trigger: with pin held high, command write with arm bit starts the flash
// - on time-out: end flash, clear running flag, attention low 11 us, ready
// - running flag high throughout flash mode
module flmc_mode_ctrl #(
    parameter int TW = 16,
    parameter int CHARGE_CYC = `FLMC_CHARGE_CYC,
    parameter int ATN_CYC = `FLMC_ATNPULSE_CYC
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic flash_trigger_pin,
    input wire logic addrSelPin,
    input wire logic outputAbove100mV,
    input wire logic openLedDet,
    input wire logic ledTempWarnDet,
    input wire logic ledTempExcessDet,
    input wire logic chipOverheatDet,
    input wire logic power_up_bit,
    input wire logic thermistor_enable,
    input wire logic torch_enable_bit,
    input wire logic cmdWrite,
    input wire logic cmdArm,
    input wire logic [TW-1:0] cmdTimeout,
    input wire logic tickTimeout,
    input wire logic statusRead,
    output logic [7:0] statusData,
    output logic trigger_arm_bit,
    output logic slaveAddrSel,
    output logic chargeEnable,
    output logic converterEnable,
    output logic ledConnect,
    output logic auxAllowed,
    output logic thermistor_switch,
    output logic attention_n_out,
    output logic attention_n_oe,
    output logic sdaHoldOff,
    output flmc_pkg::flmc_mode_type mode
);
    import flmc_pkg::*;

    localparam int POR_CYC = `FLMC_POR_CYC;
    localparam int CW = $clog2(CHARGE_CYC + 1);

    // ----------------------------------------------------------------
    // trigger pin synchroniser
    // ----------------------------------------------------------------
    logic [2:0] trigSync_q;
    logic trigLevel_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            trigSync_q <= 3'h0;
            trigLevel_q <= 1'b0;
        end else begin
            trigSync_q <= {trigSync_q[1:0], flash_trigger_pin};
            if (trigSync_q[1] == trigSync_q[2]) begin
                trigLevel_q <= trigSync_q[2];
            end
        end
    end
    logic trigRise;
    logic trigLevelD_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            trigLevelD_q <= 1'b0;
        end else begin
            trigLevelD_q <= trigLevel_q;
        end
    end
    assign trigRise = trigLevel_q && !trigLevelD_q;

    // ----------------------------------------------------------------
    // power-on reset timer and start-up check
    // ----------------------------------------------------------------
    flmc_mode_type mode_q;
    logic [9:0] porCnt_q;
    logic [CW-1:0] chargeCnt_q;
    logic checkFailed_q;
    logic timeoutHit;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            porCnt_q <= 10'h000;
            slaveAddrSel <= 1'b0;
        end else if (mode_q == FLMC_POR) begin
            porCnt_q <= porCnt_q + 10'h001;
            slaveAddrSel <= addrSelPin;
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            chargeCnt_q <= '0;
            checkFailed_q <= 1'b0;
        end else if (mode_q == FLMC_CHECK) begin
            chargeCnt_q <= chargeCnt_q + CW'(1);
            if (!outputAbove100mV && chargeCnt_q == CW'(CHARGE_CYC - 1)) begin
                checkFailed_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // latched status flags, cleared by a read; set wins
    // ----------------------------------------------------------------
    logic [4:0] setEv;
    logic [4:0] flags_q;
    logic shortSet;
    assign shortSet = (mode_q == FLMC_POR && porCnt_q == 10'(POR_CYC - 1))
        || (mode_q == FLMC_CHECK && !outputAbove100mV);
    assign setEv = {openLedDet, ledTempWarnDet, ledTempExcessDet, chipOverheatDet, 1'b0};
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            flags_q <= 5'h00;
        end else begin
            for (int i = 1; i < 5; i++) begin
                if (mode_q != FLMC_POR && setEv[i]) begin
                    flags_q[i] <= 1'b1;
                end else if (statusRead) begin
                    flags_q[i] <= 1'b0;
                end
            end
            if (shortSet || checkFailed_q) begin
                flags_q[0] <= 1'b1;
            end else if (statusRead || (mode_q == FLMC_CHECK && outputAbove100mV)) begin
                flags_q[0] <= 1'b0;
            end
        end
    end
    logic forceReady;
    assign forceReady = flags_q[4] | flags_q[2] | flags_q[1] | flags_q[0];

    // ----------------------------------------------------------------
    // time-out counter and arm bit
    // ----------------------------------------------------------------
    logic [TW-1:0] timeLeft_q;
    logic inFlash;
    assign inFlash = (mode_q == FLMC_FLASH);
    assign timeoutHit = inFlash && tickTimeout && timeLeft_q <= TW'(1);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            timeLeft_q <= '0;
        end else if (cmdWrite) begin
            timeLeft_q <= cmdTimeout;
        end else if (inFlash && tickTimeout && timeLeft_q != '0) begin
            timeLeft_q <= timeLeft_q - TW'(1);
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            trigger_arm_bit <= 1'b0;
        end else if (cmdWrite) begin
            trigger_arm_bit <= cmdArm;
        end else if (timeoutHit || (inFlash && timeLeft_q == '0)) begin
            trigger_arm_bit <= 1'b0;
        end else if (mode_q == FLMC_SHUT) begin
            trigger_arm_bit <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // mode sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mode_q <= FLMC_POR;
        end else begin
            case (mode_q)
                FLMC_POR: begin
                    if (porCnt_q == 10'(POR_CYC - 1)) mode_q <= FLMC_CHECK;
                end
                FLMC_CHECK: begin
                    // a failed check still moves on, but checkFailed_q keeps it in shutdown
                    if (outputAbove100mV || checkFailed_q) mode_q <= FLMC_SHUT;
                end
                FLMC_SHUT: begin
                    if (power_up_bit && !checkFailed_q) mode_q <= FLMC_READY;
                end
                FLMC_READY: begin
                    if (!power_up_bit) mode_q <= FLMC_SHUT;
                    else if (trigger_arm_bit && trigLevel_q && timeLeft_q != '0 && !forceReady)
                        mode_q <= FLMC_FLASH;
                    else if (torch_enable_bit && !forceReady) mode_q <= FLMC_TORCH;
                end
                FLMC_FLASH: begin
                    if (!power_up_bit) mode_q <= FLMC_SHUT;
                    else if (!trigLevel_q || !trigger_arm_bit || timeoutHit
                        || timeLeft_q == '0 || forceReady)
                        mode_q <= FLMC_READY;
                end
                FLMC_TORCH: begin
                    if (!power_up_bit) mode_q <= FLMC_SHUT;
                    else if (!torch_enable_bit || forceReady) mode_q <= FLMC_READY;
                end
                default: mode_q <= FLMC_POR;
            endcase
        end
    end
    assign mode = mode_q;

    // ----------------------------------------------------------------
    // attention pulse and outputs
    // ----------------------------------------------------------------
    logic [11:0] atnCnt_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            atnCnt_q <= 12'h000;
        end else if (timeoutHit) begin
            atnCnt_q <= 12'(ATN_CYC);
        end else if (atnCnt_q != 12'h000) begin
            atnCnt_q <= atnCnt_q - 12'h001;
        end
    end
    logic atnActive;
    assign atnActive = (flags_q != 5'h00) || (atnCnt_q != 12'h000);
    assign attention_n_out = 1'b0;
    assign attention_n_oe = (mode_q != FLMC_POR) && atnActive;
    assign sdaHoldOff = (mode_q == FLMC_POR);
    assign statusData = {1'b0, inFlash, flags_q[4:1], 1'b0, flags_q[0]};
    assign chargeEnable = (mode_q == FLMC_CHECK) && !checkFailed_q;
    assign converterEnable = (mode_q == FLMC_FLASH) || (mode_q == FLMC_TORCH);
    assign ledConnect = converterEnable;
    assign auxAllowed = (mode_q == FLMC_READY);
    assign thermistor_switch = power_up_bit && thermistor_enable && mode_q != FLMC_POR;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence seqTimeout;
        timeoutHit;
    endsequence
    AST_TIMEOUT_READY: assert property (@(posedge clock) disable iff (!rstn)
        seqTimeout |=> mode_q == FLMC_READY && !trigger_arm_bit)
        else $error("time-out did not return to ready");
    AST_ATN_PULSE: assert property (@(posedge clock) disable iff (!rstn)
        seqTimeout |=> attention_n_oe [*8])
        else $error("attention pulse too short");
    AST_RUN_FLAG: assert property (@(posedge clock) disable iff (!rstn)
        statusData[`FLMC_BIT_RUN] == (mode_q == FLMC_FLASH))
        else $error("running flag wrong");
    AST_FORCE_READY: assert property (@(posedge clock) disable iff (!rstn)
        (mode_q == FLMC_TORCH && chipOverheatDet && power_up_bit) |=> ##1 mode_q == FLMC_READY)
        else $error("fault did not force ready");
    AST_READ_CLEAR: assert property (@(posedge clock) disable iff (!rstn)
        (statusRead && setEv == 5'h00 && mode_q == FLMC_READY && !checkFailed_q)
        |=> flags_q == 5'h00)
        else $error("read did not clear flags");
    AST_SHUTDOWN: assert property (@(posedge clock) disable iff (!rstn)
        (mode_q == FLMC_READY && !power_up_bit) |=> mode_q == FLMC_SHUT)
        else $error("power bit clear did not shut down");
    AST_NO_START: assert property (@(posedge clock) disable iff (!rstn)
        checkFailed_q |-> !converterEnable && attention_n_oe)
        else $error("failed check allowed start");
    AST_RELOAD: assert property (@(posedge clock) disable iff (!rstn)
        cmdWrite |=> timeLeft_q == $past(cmdTimeout))
        else $error("command write did not reload");

    sequence seqPinStart;
        mode_q == FLMC_READY && power_up_bit && trigRise && trigger_arm_bit
            && timeLeft_q != '0 && !forceReady;
    endsequence
    AST_PIN_START: assert property (@(posedge clock) disable iff (!rstn)
        seqPinStart |=> mode_q == FLMC_FLASH)
        else $error("pin edge did not start flash");

    AST_CHECK_PASS: assert property (@(posedge clock) disable iff (!rstn)
        (mode_q == FLMC_CHECK && outputAbove100mV && !checkFailed_q)
        |=> mode_q == FLMC_SHUT && !flags_q[0])
        else $error("passed check did not clear short flag");

    AST_POR_QUIET: assert property (@(posedge clock) disable iff (!rstn)
        mode_q == FLMC_POR |-> sdaHoldOff && !attention_n_oe && !converterEnable)
        else $error("reset state not quiet");

    AST_WARN_RUNS: assert property (@(posedge clock) disable iff (!rstn)
        (mode_q == FLMC_TORCH && power_up_bit && torch_enable_bit && !forceReady
            && !openLedDet && !ledTempExcessDet && !chipOverheatDet)
        |=> mode_q == FLMC_TORCH)
        else $error("warning stopped torch");

    AST_RUN_NO_ATN: assert property (@(posedge clock) disable iff (!rstn)
        (mode_q == FLMC_FLASH && flags_q == 5'h00 && atnCnt_q == 12'h000) |-> !attention_n_oe)
        else $error("running flag drove attention");
endmodule

// file: flmc_host.sv
module flmc_host (
    input wire logic clock,
    output logic flash_trigger_pin,
    output logic power_up_bit,
    output logic thermistor_enable,
    output logic torch_enable_bit,
    output logic cmdWrite,
    output logic cmdArm,
    output logic [15:0] cmdTimeout,
    output logic statusRead
);
    timeunit 1ns;
    timeprecision 100ps;
    logic linkClk = 1'b0;
    initial begin
        {flash_trigger_pin, power_up_bit, thermistor_enable, torch_enable_bit} = 4'h0;
        {cmdWrite, cmdArm, statusRead} = 3'h0;
        cmdTimeout = 16'h0000;
        #1.3;
        forever #40 linkClk = ~linkClk;
    end
    // pin edges follow the host's own 80 ns timer, unrelated to the block clock
    task automatic pin(input logic v);
        @(posedge linkClk);
        flash_trigger_pin = v;
    endtask
    task automatic cfg(input logic pw, input logic th, input logic tc);
        @(posedge clock);
        #1 {power_up_bit, thermistor_enable, torch_enable_bit} = {pw, th, tc};
    endtask
    // arm and time-out always travel together in one command write
    task automatic cmd(input logic arm, input logic [15:0] to);
        @(posedge clock);
        #1 {cmdWrite, cmdArm, cmdTimeout} = {1'b1, arm, to};
        @(posedge clock);
        #1 cmdWrite = 1'b0;
    endtask
    task automatic rd();
        @(posedge clock);
        #1 statusRead = 1'b1;
        @(posedge clock);
        #1 statusRead = 1'b0;
    endtask
endmodule

// file: flmc_mode_ctrl_tb_top.sv
module flmc_mode_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import flmc_pkg::*;
    typedef struct {int id; logic [7:0] v;} flmc_note_type;
    localparam int ATTENTION_N = 10;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic addrSelPin = 1'b0;
    logic outputAbove100mV = 1'b0;
    logic tickTimeout = 1'b0;
    logic [3:0] det = 4'h0;
    logic flash_trigger_pin, power_up_bit, thermistor_enable, torch_enable_bit;
    logic cmdWrite, cmdArm, statusRead, aSel;
    logic [15:0] cmdTimeout;
    logic [7:0] statusData;
    logic trigger_arm_bit, slaveAddrSel, chargeEnable, converterEnable, ledConnect;
    logic auxAllowed, thermistor_switch, attention_n_out, attention_n_oe, sdaHoldOff;
    flmc_mode_type mode;
    flmc_note_type notes[$];
    flmc_note_type cur;
    int n_mismatch = 0;
    int check_count = 0;
    int seed = 32'h8f62ce07;
    int nt;
    flmc_mode_ctrl #(.CHARGE_CYC(20), .ATN_CYC(ATTENTION_N)) i_flmc_mode_ctrl (
        .clock, .rstn, .flash_trigger_pin, .addrSelPin, .outputAbove100mV,
        .openLedDet(det[3]), .ledTempWarnDet(det[2]), .ledTempExcessDet(det[1]),
        .chipOverheatDet(det[0]), .power_up_bit, .thermistor_enable, .torch_enable_bit,
        .cmdWrite, .cmdArm, .cmdTimeout, .tickTimeout, .statusRead, .statusData,
        .trigger_arm_bit, .slaveAddrSel, .chargeEnable, .converterEnable, .ledConnect,
        .auxAllowed, .thermistor_switch, .attention_n_out, .attention_n_oe, .sdaHoldOff,
        .mode);
    flmc_host i_flmc_host (.clock, .flash_trigger_pin, .power_up_bit, .thermistor_enable,
        .torch_enable_bit, .cmdWrite, .cmdArm, .cmdTimeout, .statusRead);
    initial begin
        forever #2 clock = ~clock;
    end
    function automatic logic [7:0] obs(input int id);
        case (id)
            0: return 8'(mode);
            1: return statusData;
            2: return {7'h00, attention_n_oe};
            3: return {7'h00, trigger_arm_bit};
            4: return {5'h00, converterEnable, ledConnect, auxAllowed};
            5: return {6'h00, thermistor_switch, slaveAddrSel};
            default: return {5'h00, chargeEnable, sdaHoldOff, attention_n_out};
        endcase
    endfunction
    task automatic compare(input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    // the watcher judges every queued note once outputs have settled
    always @(negedge clock) begin
        while (notes.size() > 0) begin
            cur = notes.pop_front();
            compare(cur.v, obs(cur.id));
        end
    end
    task automatic chk(input int id, input logic [7:0] v);
        notes.push_back('{id, v});
        @(negedge clock);
    endtask
    task automatic chm(input flmc_mode_type m);
        chk(0, 8'(m));
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wait_mode(input flmc_mode_type m);
        for (int k = 0; k < 60 && mode !== m; k++) cyc(1);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            cyc(1);
            tickTimeout = 1'b1;
            cyc(1);
            tickTimeout = 1'b0;
        end
    endtask
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #60000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        aSel = 1'($random(seed));
        addrSelPin = aSel;
        cyc(20);
        rstn = 1'b1;
        chk(6, 8'h02);
        cyc(260);
        chm(FLMC_CHECK);
        chk(1, 8'h01);
        chk(6, 8'h04);
        addrSelPin = ~aSel;
        outputAbove100mV = 1'b1;
        wait_mode(FLMC_SHUT);
        chk(1, 8'h00);
        chk(2, 8'h00);
        i_flmc_host.cfg(1'b0, 1'b1, 1'b0);
        chk(5, {7'h00, aSel});
        i_flmc_host.cfg(1'b1, 1'b1, 1'b0);
        wait_mode(FLMC_READY);
        chm(FLMC_READY);
        chk(4, 8'h01);
        chk(5, {7'h01, aSel});
        $display("startup done");
        nt = 2 + ($unsigned($random(seed)) % 4);
        i_flmc_host.pin(1'b1);
        i_flmc_host.cmd(1'b1, 16'(nt));
        wait_mode(FLMC_FLASH);
        chk(1, 8'h40);
        chk(2, 8'h00);
        ticks(nt);
        wait_mode(FLMC_READY);
        chk(2, 8'h01);
        cyc(ATTENTION_N - 3);
        chk(2, 8'h01);
        cyc(3);
        chk(2, 8'h00);
        chk(3, 8'h00);
        chk(1, 8'h00);
        $display("soft flash done");
        i_flmc_host.pin(1'b0);
        i_flmc_host.cmd(1'b1, 16'h0004);
        cyc(5);
        chm(FLMC_READY);
        for (int f = 0; f < 2; f++) begin
            i_flmc_host.pin(1'b1);
            wait_mode(FLMC_FLASH);
            chm(FLMC_FLASH);
            ticks(2);
            if (f == 0) i_flmc_host.pin(1'b0);
            wait_mode(FLMC_READY);
            chk(3, 8'(f == 0));
        end
        i_flmc_host.cmd(1'b1, 16'h0009);
        wait_mode(FLMC_FLASH);
        chm(FLMC_FLASH);
        i_flmc_host.cmd(1'b0, 16'h0009);
        wait_mode(FLMC_READY);
        chm(FLMC_READY);
        $display("pin flash done");
        for (int i = 0; i < 4; i++) begin
            i_flmc_host.cfg(1'b1, 1'b1, 1'b1);
            wait_mode(FLMC_TORCH);
            det[i] = 1'b1;
            cyc(1);
            det[i] = 1'b0;
            cyc(2);
            chk(1, 8'(1 << (i + 2)));
            chk(2, 8'h01);
            chm(i == 2 ? FLMC_TORCH : FLMC_READY);
            chk(4, i == 2 ? 8'h06 : 8'h01);
            i_flmc_host.rd();
            cyc(1);
            chk(1, 8'h00);
            chk(2, 8'h00);
            i_flmc_host.cfg(1'b1, 1'b1, 1'b0);
            wait_mode(FLMC_READY);
            chm(FLMC_READY);
        end
        i_flmc_host.cfg(1'b0, 1'b0, 1'b0);
        wait_mode(FLMC_SHUT);
        chm(FLMC_SHUT);
        $display("fault and shutdown done");
        outputAbove100mV = 1'b0;
        rstn = 1'b0;
        cyc(2);
        rstn = 1'b1;
        cyc(300);
        chk(1, 8'h01);
        chk(2, 8'h01);
        i_flmc_host.cfg(1'b1, 1'b0, 1'b0);
        cyc(5);
        chk(4, 8'h00);
        chm(FLMC_SHUT);
        $display("failed start done");
        cyc(1);
        wrap_up();
    end
endmodule
